// file: core/serial_sync_regs_defines.vh
// Register map, field positions and reset values of the serial sync status block
`ifndef SERIAL_SYNC_REGS_DEFINES_VH
`define SERIAL_SYNC_REGS_DEFINES_VH

// Byte addresses
`define ADDR_RX_SYNC_HOLDING  32'hf0010030
`define ADDR_TX_SYNC_HOLDING  32'hf0010034
`define ADDR_RX_COMPARE_A     32'hf0010038
`define ADDR_RX_COMPARE_B     32'hf001003c
`define ADDR_EVENT_FLAGS      32'hf0010040
`define ADDR_IRQ_ENABLE_SET   32'hf0010044
`define ADDR_IRQ_ENABLE_CLEAR 32'hf0010048
`define ADDR_IRQ_ENABLE_VIEW  32'hf001004c
`define ADDR_LINK_CONTROL     32'hf0010050
`define ADDR_WRITE_LOCK       32'hf00100e4

// Status flag positions
`define BIT_TX_HOLDING_FREE    0
`define BIT_TX_FULLY_DRAINED   1
`define BIT_RX_WORD_AVAILABLE  4
`define BIT_RX_WORD_LOST       5
`define BIT_COMPARE_MATCH_A    8
`define BIT_COMPARE_MATCH_B    9
`define BIT_TX_FRAME_SYNC_SEEN 10
`define BIT_RX_FRAME_SYNC_SEEN 11
`define BIT_TRANSMITTER_ON     16
`define BIT_RECEIVER_ON        17
`define FLAG_MASK              32'h00000f33

// Link control field positions
`define BIT_CTL_TX_ON          0
`define BIT_CTL_RX_ON          1
`define BIT_CTL_SYNC_OUT_ON    2
`define BIT_CTL_EDGE_SELECT    3

// Write lock fields
`define BIT_WRITE_LOCK_ON      0
`define WRITE_LOCK_PASSWORD    24'h535343

// Reset values
`define RST_SYNC_WORD          16'h0000
`define RST_COMPARE            16'h0000
`define RST_IRQ_ENABLE         12'h000
`define RST_CONTROL            4'h0

// AXI responses
`define RESP_OKAY              2'b00
`define RESP_SLVERR            2'b10

`endif

// file: core/serial_sync_status_irq_regs.v
// Status, interrupt and sync holding registers of a synchronous serial controller
//
// Added by the designer: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "serial_sync_regs_defines.vh"

module serial_sync_status_irq_regs #(
  parameter SYNC_W = 16
) (
  // Clock and reset
  input  wire              CLK,
  input  wire              RESET_N,
  // AXI4-Lite write address
  input  wire [31:0]       AWADDR,
  input  wire              AWVALID,
  output reg               AWREADY,
  // AXI4-Lite write data
  input  wire [31:0]       WDATA,
  input  wire [3:0]        WSTRB,
  input  wire              WVALID,
  output reg               WREADY,
  // AXI4-Lite write response
  output reg  [1:0]        BRESP,
  output reg               BVALID,
  input  wire              BREADY,
  // AXI4-Lite read address
  input  wire [31:0]       ARADDR,
  input  wire              ARVALID,
  output reg               ARREADY,
  // AXI4-Lite read data
  output reg  [31:0]       RDATA,
  output reg  [1:0]        RRESP,
  output reg               RVALID,
  input  wire              RREADY,
  // Transmit holding events
  input  wire              TX_HOLD_WRITE,
  input  wire              TX_HOLD_TAKEN,
  input  wire              TX_SHIFT_DONE,
  // Receive holding events
  input  wire              RX_HOLD_LOAD,
  input  wire              RX_HOLD_READ,
  input  wire [SYNC_W-1:0] RX_DATA,
  // Frame sync
  input  wire              TX_FRAME_SYNC,
  input  wire              TX_BIT_STROBE,
  input  wire              TX_DATA_DEFAULT,
  input  wire              RX_SYNC_EVENT,
  input  wire [SYNC_W-1:0] RX_SYNC_DATA,
  // Outputs to the serial logic
  output reg               TX_SYNC_BIT,
  output reg               TRANSMITTER_ON,
  output reg               RECEIVER_ON,
  output reg               IRQ
);
  // Expand byte strobes into a bit mask
  function [31:0] strb_mask;
    input [3:0] strb;
    begin
      strb_mask = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction
  // One for every address that holds a register
  function addr_mapped;
    input [31:0] addr;
    begin
      case (addr)
        `ADDR_RX_SYNC_HOLDING, `ADDR_TX_SYNC_HOLDING,
        `ADDR_RX_COMPARE_A, `ADDR_RX_COMPARE_B,
        `ADDR_EVENT_FLAGS, `ADDR_IRQ_ENABLE_SET,
        `ADDR_IRQ_ENABLE_CLEAR, `ADDR_IRQ_ENABLE_VIEW,
        `ADDR_LINK_CONTROL, `ADDR_WRITE_LOCK: addr_mapped = 1'b1;
        default: addr_mapped = 1'b0;
      endcase
    end
  endfunction
  // Register state
  reg  [31:0]       awaddr_reg;
  reg  [31:0]       wdata_reg;
  reg  [3:0]        wstrb_reg;
  reg  [SYNC_W-1:0] rx_sync_word_reg;
  reg  [SYNC_W-1:0] tx_sync_word_reg;
  reg  [SYNC_W-1:0] compare_a_reg;
  reg  [SYNC_W-1:0] compare_b_reg;
  reg  [11:0]       irq_enable_reg;
  reg  [11:0]       irq_enable_next;
  reg  [3:0]        control_reg;
  reg               write_lock_on_reg;
  reg               tx_holding_free_reg;
  reg               tx_fully_drained_reg;
  reg               rx_word_available_reg;
  reg               rx_word_lost_reg;
  reg               compare_match_a_reg;
  reg               compare_match_b_reg;
  reg               tx_frame_sync_seen_reg;
  reg               rx_frame_sync_seen_reg;
  reg               tx_holding_free_next;
  reg               tx_fully_drained_next;
  reg               rx_word_available_next;
  reg               rx_word_lost_next;
  reg               compare_match_a_next;
  reg               compare_match_b_next;
  reg               tx_frame_sync_seen_next;
  reg               rx_frame_sync_seen_next;
  reg               frame_sync_prev_reg;
  reg  [SYNC_W-1:0] sync_shift_reg;
  reg  [31:0]       read_value;
  reg  [11:0]       flags_view;
  wire [31:0] wmask    = strb_mask(wstrb_reg);
  wire [31:0] wmerged_tsh = ({16'h0000, tx_sync_word_reg} & ~wmask) | (wdata_reg & wmask);
  wire [31:0] wmerged_ca  = ({16'h0000, compare_a_reg} & ~wmask) | (wdata_reg & wmask);
  wire [31:0] wmerged_cb  = ({16'h0000, compare_b_reg} & ~wmask) | (wdata_reg & wmask);
  // Write data cut to the lanes written and to the flag positions
  wire [31:0] wmasked  = wdata_reg & wmask & `FLAG_MASK;
  // Write fires once both halves are held and no response is pending
  wire wr_go    = !AWREADY && !WREADY && !BVALID;
  wire rd_take  = ARVALID && ARREADY;
  wire sr_read  = rd_take && (ARADDR == `ADDR_EVENT_FLAGS);
  wire wr_at    = wr_go;
  // Event decoding
  wire sync_rise  = TX_FRAME_SYNC && !frame_sync_prev_reg;
  wire sync_fall  = !TX_FRAME_SYNC && frame_sync_prev_reg;
  wire edge_sel   = control_reg[`BIT_CTL_EDGE_SELECT];
  wire tx_sync_ev = edge_sel ? sync_fall : sync_rise;
  wire match_a    = RX_HOLD_LOAD && (RX_DATA == compare_a_reg);
  wire match_b    = RX_HOLD_LOAD && (RX_DATA == compare_b_reg);
  // Status flags in register layout
  always @* begin
    flags_view = 12'h000;
    flags_view[`BIT_TX_HOLDING_FREE]    = tx_holding_free_reg;
    flags_view[`BIT_TX_FULLY_DRAINED]   = tx_fully_drained_reg;
    flags_view[`BIT_RX_WORD_AVAILABLE]  = rx_word_available_reg;
    flags_view[`BIT_RX_WORD_LOST]       = rx_word_lost_reg;
    flags_view[`BIT_COMPARE_MATCH_A]    = compare_match_a_reg;
    flags_view[`BIT_COMPARE_MATCH_B]    = compare_match_b_reg;
    flags_view[`BIT_TX_FRAME_SYNC_SEEN] = tx_frame_sync_seen_reg;
    flags_view[`BIT_RX_FRAME_SYNC_SEEN] = rx_frame_sync_seen_reg;
  end
  // Read data multiplexer
  always @* begin
    read_value = 32'h00000000;
    case (ARADDR)
      `ADDR_RX_SYNC_HOLDING: read_value = {16'h0000, rx_sync_word_reg};
      `ADDR_TX_SYNC_HOLDING: read_value = {16'h0000, tx_sync_word_reg};
      `ADDR_RX_COMPARE_A:    read_value = {16'h0000, compare_a_reg};
      `ADDR_RX_COMPARE_B:    read_value = {16'h0000, compare_b_reg};
      `ADDR_EVENT_FLAGS: begin
        read_value[11:0]                 = flags_view;
        read_value[`BIT_TRANSMITTER_ON] = control_reg[`BIT_CTL_TX_ON];
        read_value[`BIT_RECEIVER_ON]    = control_reg[`BIT_CTL_RX_ON];
      end
      `ADDR_IRQ_ENABLE_VIEW: read_value = {20'h00000, irq_enable_reg};
      `ADDR_LINK_CONTROL:    read_value = {28'h0000000, control_reg};
      `ADDR_WRITE_LOCK:      read_value = {31'h00000000, write_lock_on_reg};
      default:               read_value = 32'h00000000;
    endcase
  end
  // Next values of the event flags; a set beats a clear, except on the transmit holding free and fully drained flags, where the clear wins
  always @* begin
    tx_holding_free_next    = tx_holding_free_reg;
    tx_fully_drained_next   = tx_fully_drained_reg;
    rx_word_available_next  = rx_word_available_reg;
    rx_word_lost_next       = rx_word_lost_reg;
    compare_match_a_next    = compare_match_a_reg;
    compare_match_b_next    = compare_match_b_reg;
    tx_frame_sync_seen_next = tx_frame_sync_seen_reg;
    rx_frame_sync_seen_next = rx_frame_sync_seen_reg;
    // Transmit holding word waits until the shifter takes it
    if (TX_HOLD_WRITE) begin
      tx_holding_free_next = 1'b0;
    end else if (TX_HOLD_TAKEN) begin
      tx_holding_free_next = 1'b1;
    end
    // Drained only when nothing waits and the shifter has finished
    if (TX_HOLD_WRITE || TX_HOLD_TAKEN) begin
      tx_fully_drained_next = 1'b0;
    end else if (TX_SHIFT_DONE && tx_holding_free_reg) begin
      tx_fully_drained_next = 1'b1;
    end
    // Receive word tracking
    if (RX_HOLD_LOAD) begin
      rx_word_available_next = 1'b1;
    end else if (RX_HOLD_READ) begin
      rx_word_available_next = 1'b0;
    end
    // Sticky flags clear on a status read
    if (sr_read) begin
      rx_word_lost_next       = 1'b0;
      compare_match_a_next    = 1'b0;
      compare_match_b_next    = 1'b0;
      tx_frame_sync_seen_next = 1'b0;
      rx_frame_sync_seen_next = 1'b0;
    end
    if (RX_HOLD_LOAD && rx_word_available_reg && !RX_HOLD_READ) begin
      rx_word_lost_next = 1'b1;
    end
    if (match_a) begin
      compare_match_a_next = 1'b1;
    end
    if (match_b) begin
      compare_match_b_next = 1'b1;
    end
    if (tx_sync_ev) begin
      tx_frame_sync_seen_next = 1'b1;
    end
    if (RX_SYNC_EVENT) begin
      rx_frame_sync_seen_next = 1'b1;
    end
  end
  // Next value of the interrupt enable mask
  always @* begin
    irq_enable_next = irq_enable_reg;
    if (wr_at && awaddr_reg == `ADDR_IRQ_ENABLE_SET) begin
      irq_enable_next = irq_enable_reg | wmasked[11:0];
    end else if (wr_at && awaddr_reg == `ADDR_IRQ_ENABLE_CLEAR) begin
      irq_enable_next = irq_enable_reg & ~wmasked[11:0];
    end
  end
  // Write channel handshake and response
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AWREADY    <= 1'b1;
      WREADY     <= 1'b1;
      BVALID     <= 1'b0;
      BRESP      <= `RESP_OKAY;
      awaddr_reg <= 32'h00000000;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (AWVALID && AWREADY) begin
        awaddr_reg <= AWADDR;
        AWREADY    <= 1'b0;
      end
      if (WVALID && WREADY) begin
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
        WREADY    <= 1'b0;
      end
      if (wr_go) begin
        BVALID <= 1'b1;
        BRESP  <= addr_mapped(awaddr_reg) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID  <= 1'b0;
        AWREADY <= 1'b1;
        WREADY  <= 1'b1;
      end
    end
  end
  // Read channel handshake
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ARREADY <= 1'b1;
      RVALID  <= 1'b0;
      RDATA   <= 32'h00000000;
      RRESP   <= `RESP_OKAY;
    end else begin
      if (rd_take) begin
        ARREADY <= 1'b0;
        RVALID  <= 1'b1;
        RDATA   <= read_value;
        RRESP   <= addr_mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RVALID && RREADY) begin
        RVALID  <= 1'b0;
        ARREADY <= 1'b1;
      end
    end
  end
  // Software-written registers
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_sync_word_reg  <= `RST_SYNC_WORD;
      compare_a_reg     <= `RST_COMPARE;
      compare_b_reg     <= `RST_COMPARE;
      control_reg       <= `RST_CONTROL;
      write_lock_on_reg <= 1'b0;
      irq_enable_reg    <= `RST_IRQ_ENABLE;
    end else begin
      irq_enable_reg <= irq_enable_next;
      if (wr_at) begin
        case (awaddr_reg)
          `ADDR_TX_SYNC_HOLDING: tx_sync_word_reg <= wmerged_tsh[15:0];
          `ADDR_RX_COMPARE_A: begin
            if (!write_lock_on_reg) begin
              compare_a_reg <= wmerged_ca[15:0];
            end
          end
          `ADDR_RX_COMPARE_B: begin
            if (!write_lock_on_reg) begin
              compare_b_reg <= wmerged_cb[15:0];
            end
          end
          `ADDR_LINK_CONTROL: begin
            if (wstrb_reg[0]) begin
              control_reg <= wdata_reg[3:0];
            end
          end
          `ADDR_WRITE_LOCK: begin
            if (wstrb_reg == 4'hf && wdata_reg[31:8] == `WRITE_LOCK_PASSWORD) begin
              write_lock_on_reg <= wdata_reg[`BIT_WRITE_LOCK_ON];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  // Event flags and received sync word
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx_holding_free_reg    <= 1'b1;
      tx_fully_drained_reg   <= 1'b1;
      rx_word_available_reg  <= 1'b0;
      rx_word_lost_reg       <= 1'b0;
      compare_match_a_reg    <= 1'b0;
      compare_match_b_reg    <= 1'b0;
      tx_frame_sync_seen_reg <= 1'b0;
      rx_frame_sync_seen_reg <= 1'b0;
      rx_sync_word_reg       <= `RST_SYNC_WORD;
      frame_sync_prev_reg    <= 1'b0;
    end else begin
      tx_holding_free_reg    <= tx_holding_free_next;
      tx_fully_drained_reg   <= tx_fully_drained_next;
      rx_word_available_reg  <= rx_word_available_next;
      rx_word_lost_reg       <= rx_word_lost_next;
      compare_match_a_reg    <= compare_match_a_next;
      compare_match_b_reg    <= compare_match_b_next;
      tx_frame_sync_seen_reg <= tx_frame_sync_seen_next;
      rx_frame_sync_seen_reg <= rx_frame_sync_seen_next;
      frame_sync_prev_reg    <= TX_FRAME_SYNC;
      if (RX_SYNC_EVENT) begin
        rx_sync_word_reg <= RX_SYNC_DATA;
      end
    end
  end
  // Sync word shifter, LSB first, one bit per strobe during the pulse
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sync_shift_reg <= `RST_SYNC_WORD;
      TX_SYNC_BIT    <= 1'b0;
    end else if (sync_rise) begin
      sync_shift_reg <= tx_sync_word_reg;
      TX_SYNC_BIT    <= TX_DATA_DEFAULT;
    end else if (TX_FRAME_SYNC && TX_BIT_STROBE) begin
      sync_shift_reg <= {1'b0, sync_shift_reg[SYNC_W-1:1]};
      if (control_reg[`BIT_CTL_SYNC_OUT_ON]) begin
        TX_SYNC_BIT <= sync_shift_reg[0];
      end else begin
        TX_SYNC_BIT <= TX_DATA_DEFAULT;
      end
    end else if (!TX_FRAME_SYNC) begin
      TX_SYNC_BIT <= TX_DATA_DEFAULT;
    end
  end
  // Enable levels and interrupt output
  always @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      TRANSMITTER_ON <= 1'b0;
      RECEIVER_ON    <= 1'b0;
      IRQ            <= 1'b0;
    end else begin
      TRANSMITTER_ON <= control_reg[`BIT_CTL_TX_ON];
      RECEIVER_ON    <= control_reg[`BIT_CTL_RX_ON];
      IRQ            <= |(flags_view & irq_enable_reg);
    end
  end

endmodule // serial_sync_status_irq_regs
`default_nettype wire

// file: testbench/serial_sync_chk.sv
// Port-level assertions for the serial sync status and interrupt registers
`timescale 1ns/100ps
`default_nettype none
module serial_sync_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // Register bus handshakes
  input wire logic        AWVALID,
  input wire logic        AWREADY,
  input wire logic        WVALID,
  input wire logic        WREADY,
  input wire logic [1:0]  BRESP,
  input wire logic        BVALID,
  input wire logic        BREADY,
  input wire logic        ARVALID,
  input wire logic        ARREADY,
  input wire logic [31:0] RDATA,
  input wire logic        RVALID,
  input wire logic        RREADY,
  // Serial side
  input wire logic        TX_FRAME_SYNC,
  input wire logic        TX_DATA_DEFAULT,
  input wire logic        TX_SYNC_BIT,
  input wire logic        TRANSMITTER_ON,
  input wire logic        RECEIVER_ON
);
  // All checks run on the bus clock and pause in reset
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);

  // Read answers arrive one edge after the request is taken, write answers two edges after
  chk_write_answer: assert property (AWVALID && AWREADY && WVALID && WREADY |=> !AWREADY ##1 BVALID)
    else $error("write not answered in time");
  chk_read_answer: assert property (ARVALID && ARREADY |=> RVALID && !ARREADY)
    else $error("read not answered in time");
  // Answers stand until taken
  chk_rdata_hold: assert property (RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data dropped before taken");
  chk_bresp_hold: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped before taken");
  // Readies come back after the answer is taken
  chk_write_release: assert property (BVALID && BREADY |=> !BVALID ##[0:1] (AWREADY && WREADY))
    else $error("write channel not released");
  chk_read_release: assert property (RVALID && RREADY |=> !RVALID ##[0:1] ARREADY)
    else $error("read channel not released");
  // Outside the sync pulse the line carries the default level
  chk_sync_idle: assert property (!TX_FRAME_SYNC |=> TX_SYNC_BIT == $past(TX_DATA_DEFAULT))
    else $error("sync line not at default level");
  // Enable levels only move as a result of a register write
  chk_enable_cause: assert property ($changed({TRANSMITTER_ON, RECEIVER_ON}) |-> !$past(WREADY) || !$past(WREADY, 2))
    else $error("enable level moved without a write");
endmodule // serial_sync_chk
`default_nettype wire

// file: testbench/test_serial_sync_status_irq_regs.sv
// Self-checking bench for the serial sync status and interrupt registers
`timescale 1ns/100ps
`default_nettype none
`include "serial_sync_regs_defines.vh"
module test_serial_sync_status_irq_regs;
  // Bench-driven inputs
  logic        CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [31:0] AWADDR = 32'h0, WDATA = 32'h0, ARADDR = 32'h0;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
  logic        TX_FRAME_SYNC = 1'b0, TX_BIT_STROBE = 1'b0, TX_DATA_DEFAULT = 1'b0;
  logic [5:0]  ev = 6'h00;
  logic [3:0]  WSTRB = 4'hf;
  logic [15:0] RX_DATA = 16'h0000, RX_SYNC_DATA = 16'h0000;
  // Design outputs
  wire         AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  wire         TX_SYNC_BIT, TRANSMITTER_ON, RECEIVER_ON;
  wire [1:0]   BRESP, RRESP;
  wire [31:0]  RDATA;
  integer      err_count = 0, checked = 0;
  // Event pulse codes: write, taken, shift done, load, read, rx sync
  localparam [5:0] e_hw = 6'h20, e_ht = 6'h10, e_sd = 6'h08, e_rl = 6'h04, e_rr = 6'h02, e_se = 6'h01;
  localparam [31:0] a_fl = `ADDR_EVENT_FLAGS, a_ctl = `ADDR_LINK_CONTROL, a_lk = `ADDR_WRITE_LOCK;

  always #2 CLK = ~CLK;

  serial_sync_status_irq_regs serial_sync_status_irq_regs_inst (
    .CLK(CLK), .RESET_N(RESET_N), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .TX_HOLD_WRITE(ev[5]), .TX_HOLD_TAKEN(ev[4]), .TX_SHIFT_DONE(ev[3]),
    .RX_HOLD_LOAD(ev[2]), .RX_HOLD_READ(ev[1]), .RX_DATA(RX_DATA),
    .TX_FRAME_SYNC(TX_FRAME_SYNC), .TX_BIT_STROBE(TX_BIT_STROBE),
    .TX_DATA_DEFAULT(TX_DATA_DEFAULT), .RX_SYNC_EVENT(ev[0]), .RX_SYNC_DATA(RX_SYNC_DATA),
    .TX_SYNC_BIT(TX_SYNC_BIT), .TRANSMITTER_ON(TRANSMITTER_ON), .RECEIVER_ON(RECEIVER_ON),
    .IRQ(IRQ));

  // Compare and count
  task automatic chk(input [31:0] seen, input [31:0] want);
    checked = checked + 1;
    if (seen !== want) begin
      err_count = err_count + 1;
      $display("[ERR] %0t seen %h want %h", $time, seen, want);
    end
  endtask

  // Bus write, address and data offered together
  task automatic wr(input [31:0] a, input [31:0] d, input [1:0] r);
    @(posedge CLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    BREADY <= 1'b0;
    chk({30'h0, BRESP}, {30'h0, r});
  endtask

  // Bus read, data and response judged
  task automatic rd(input [31:0] a, input [31:0] d, input [1:0] r);
    @(posedge CLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    RREADY <= 1'b0;
    chk({30'h0, RRESP}, {30'h0, r});
    chk(RDATA, d);
  endtask

  // One-cycle event pulse
  task automatic pulse(input [5:0] v);
    @(posedge CLK);
    ev <= v;
    @(posedge CLK);
    ev <= 6'h00;
  endtask

  task automatic t_reset;
    rd(a_fl, 32'h3, `RESP_OKAY);
    rd(`ADDR_IRQ_ENABLE_VIEW, 32'h0, `RESP_OKAY);
    $display("done reset values");
  endtask

  task automatic t_tx;
    pulse(e_hw);
    rd(a_fl, 32'h0, `RESP_OKAY);
    pulse(e_ht);
    rd(a_fl, 32'h1, `RESP_OKAY);
    pulse(e_sd);
    rd(a_fl, 32'h3, `RESP_OKAY);
    $display("done transmit flags");
  endtask

  task automatic t_rx;
    wr(`ADDR_RX_COMPARE_A, 32'hffff1234, `RESP_OKAY);
    wr(`ADDR_RX_COMPARE_B, 32'h0000abcd, `RESP_OKAY);
    rd(`ADDR_RX_COMPARE_A, 32'h1234, `RESP_OKAY);
    RX_DATA <= 16'h1234;
    pulse(e_rl);
    rd(a_fl, 32'h113, `RESP_OKAY);
    RX_DATA <= 16'habcd;
    pulse(e_rl);
    rd(a_fl, 32'h233, `RESP_OKAY);
    rd(a_fl, 32'h013, `RESP_OKAY);
    pulse(e_rr);
    rd(a_fl, 32'h003, `RESP_OKAY);
    $display("done receive flags");
  endtask

  task automatic t_sync;
    integer i;
    RX_SYNC_DATA <= 16'h5a5a;
    pulse(e_se);
    rd(`ADDR_RX_SYNC_HOLDING, 32'h5a5a, `RESP_OKAY);
    rd(a_fl, 32'h803, `RESP_OKAY);
    wr(a_ctl, 32'h7, `RESP_OKAY);
    wr(`ADDR_TX_SYNC_HOLDING, 32'hffffa5c3, `RESP_OKAY);
    rd(`ADDR_TX_SYNC_HOLDING, 32'ha5c3, `RESP_OKAY);
    chk({30'h0, RECEIVER_ON, TRANSMITTER_ON}, 32'h3);
    TX_DATA_DEFAULT <= 1'b1;
    TX_FRAME_SYNC <= 1'b1;
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge CLK);
      TX_BIT_STROBE <= 1'b1;
      @(posedge CLK);
      TX_BIT_STROBE <= 1'b0;
      @(posedge CLK);
      chk({31'h0, TX_SYNC_BIT}, (32'ha5c3 >> i) & 32'h1);
    end
    TX_FRAME_SYNC <= 1'b0;
    rd(a_fl, 32'h30403, `RESP_OKAY);
    wr(a_ctl, 32'h8, `RESP_OKAY);
    TX_DATA_DEFAULT <= 1'b0;
    TX_FRAME_SYNC <= 1'b1;
    pulse(6'h00);
    TX_BIT_STROBE <= 1'b1;
    pulse(6'h00);
    TX_BIT_STROBE <= 1'b0;
    chk({31'h0, TX_SYNC_BIT}, 32'h0);
    rd(a_fl, 32'h3, `RESP_OKAY);
    TX_FRAME_SYNC <= 1'b0;
    rd(a_fl, 32'h403, `RESP_OKAY);
    $display("done frame sync");
  endtask

  // Interrupt output judged once it has had time to settle
  task automatic irq_is(input [31:0] want);
    repeat (3) @(posedge CLK);
    chk({31'h0, IRQ}, want);
  endtask

  task automatic t_irq;
    wr(`ADDR_IRQ_ENABLE_SET, 32'h20, `RESP_OKAY);
    irq_is(32'h0);
    wr(`ADDR_IRQ_ENABLE_SET, 32'h13, `RESP_OKAY);
    rd(`ADDR_IRQ_ENABLE_VIEW, 32'h33, `RESP_OKAY);
    irq_is(32'h1);
    wr(`ADDR_IRQ_ENABLE_CLEAR, 32'h03, `RESP_OKAY);
    rd(`ADDR_IRQ_ENABLE_VIEW, 32'h30, `RESP_OKAY);
    irq_is(32'h0);
    pulse(e_rl);
    pulse(e_rl);
    irq_is(32'h1);
    rd(a_fl, 32'h233, `RESP_OKAY);
    pulse(e_rr);
    irq_is(32'h0);
    wr(`ADDR_IRQ_ENABLE_CLEAR, 32'hf33, `RESP_OKAY);
    rd(`ADDR_IRQ_ENABLE_VIEW, 32'h0, `RESP_OKAY);
    // Sync event lands in the very cycle that the status read clears
    fork
      rd(a_fl, 32'h3, `RESP_OKAY);
      pulse(e_se);
    join
    rd(a_fl, 32'h803, `RESP_OKAY);
    $display("done interrupts");
  endtask

  task automatic t_lock;
    wr(a_lk, 32'h53534301, `RESP_OKAY);
    wr(`ADDR_RX_COMPARE_A, 32'h1111, `RESP_OKAY);
    rd(`ADDR_RX_COMPARE_A, 32'h1234, `RESP_OKAY);
    wr(a_lk, 32'h12345600, `RESP_OKAY);
    rd(a_lk, 32'h1, `RESP_OKAY);
    wr(a_lk, 32'h53534300, `RESP_OKAY);
    wr(`ADDR_RX_COMPARE_A, 32'h1111, `RESP_OKAY);
    rd(`ADDR_RX_COMPARE_A, 32'h1111, `RESP_OKAY);
    wr(`ADDR_RX_SYNC_HOLDING, 32'h1, `RESP_OKAY);
    rd(`ADDR_RX_SYNC_HOLDING, 32'h5a5a, `RESP_OKAY);
    wr(32'hf0010100, 32'h1, `RESP_SLVERR);
    rd(32'hf0010100, 32'h0, `RESP_SLVERR);
    // Partial lanes merge into the sync word; the lock needs all lanes
    WSTRB <= 4'h1;
    wr(`ADDR_TX_SYNC_HOLDING, 32'h000000ff, `RESP_OKAY);
    WSTRB <= 4'h7;
    wr(a_lk, 32'h53534301, `RESP_OKAY);
    WSTRB <= 4'hf;
    rd(`ADDR_TX_SYNC_HOLDING, 32'ha5ff, `RESP_OKAY);
    rd(a_lk, 32'h0, `RESP_OKAY);
    $display("done write lock");
  endtask

  // Print counts and the verdict, then stop
  task automatic final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (2) @(posedge CLK);
    RESET_N <= 1'b1;
    t_reset;
    t_tx;
    t_rx;
    t_sync;
    t_irq;
    t_lock;
    final_report;
  end

  // Hang guard
  initial begin
    repeat (20000) @(posedge CLK);
    err_count = err_count + 1;
    final_report;
  end
endmodule // test_serial_sync_status_irq_regs

bind serial_sync_status_irq_regs serial_sync_chk serial_sync_chk_inst (
  .CLK(CLK), .RESET_N(RESET_N), .AWVALID(AWVALID), .AWREADY(AWREADY), .WVALID(WVALID),
  .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RVALID(RVALID), .RREADY(RREADY),
  .TX_FRAME_SYNC(TX_FRAME_SYNC), .TX_DATA_DEFAULT(TX_DATA_DEFAULT),
  .TX_SYNC_BIT(TX_SYNC_BIT), .TRANSMITTER_ON(TRANSMITTER_ON), .RECEIVER_ON(RECEIVER_ON));
`default_nettype wire
